// File: design/sleep_mode_powergood_sequencer.sv
// Sleep-mode decode, start-up and power-good sequencing, fault latch-off
`timescale 1ns/1ps
module sleep_mode_powergood_sequencer (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins and analog comparator results
  input wire logic i_enable,
  input wire logic i_sleep_request_in,
  input wire logic i_deeper_sleep_request_in,
  input wire logic [5:0] i_voltage_code,
  input wire logic i_boot_reached,
  input wire logic i_pg_sink_detect,
  input wire logic i_ov_cmp,
  input wire logic i_uv_cmp,
  input wire logic i_oc_cmp,
  input wire logic i_neg_current,
  input wire logic i_pwm_high,
  input wire logic i_power_good_pin,
  output logic o_power_good_pin,
  output logic o_power_good_pin_oe_n,
  output logic o_system_power_ok,
  output logic [3:0] o_target_sel,
  output logic [5:0] o_dac_code,
  output logic o_high_side_on,
  output logic o_low_side_on,
  output logic o_discontinuous,
  output logic o_overcurrent
);
  localparam int NSYNC = 17;

  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic en_pin;
  logic sleep_req;
  logic deeper_req;
  logic [5:0] code_in;
  logic boot_ok;
  logic sink_det;
  logic ov;
  logic uv;
  logic oc;
  logic neg_cur;
  logic pwm_hi;
  logic pg_pin;
  logic soft_enable;
  logic enabled;
  seq_pkg::seq_state_t state;
  seq_pkg::seq_state_t next_state;
  seq_pkg::mode_t mode;
  seq_pkg::mode_t next_mode;
  logic [5:0] code_held;
  logic [8:0] sw_count;
  logic sw_tick;
  logic [9:0] ramp_count;
  logic [11:0] pg_count;
  logic pg_expired;
  logic [5:0] mask_count;
  logic masked;
  logic transition;
  logic uv_trip;
  logic oc_trip;
  logic ov_latch;
  logic any_fault;
  logic regulating;
  logic dcm_en;
  logic tristate;
  logic pg_good;
  logic apb_access;
  logic [31:0] status_word;

  // Two-flop synchroniser for every asynchronous input
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {i_enable, i_sleep_request_in, i_deeper_sleep_request_in, i_voltage_code,
                 i_boot_reached, i_pg_sink_detect, i_ov_cmp, i_uv_cmp, i_oc_cmp,
                 i_neg_current, i_pwm_high, i_power_good_pin};
      sync_b <= sync_a;
    end
  end

  // Name the synchronised inputs
  assign {en_pin, sleep_req, deeper_req, code_in, boot_ok, sink_det, ov, uv, oc,
          neg_cur, pwm_hi, pg_pin} = sync_b;
  assign enabled = en_pin && soft_enable;

  // Switching-cycle clock from the system clock
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || sw_tick)
      sw_count <= 9'h000;
    else
      sw_count <= sw_count + 9'h001;
  end
  assign sw_tick = (sw_count == 9'(seq_pkg::SW_PERIOD_CYCLES - 1));

  // Mode decode from the two sleep request inputs
  always_comb
  begin
    if (deeper_req)
      next_mode = seq_pkg::MODE_DEEPER;
    else if (sleep_req)
      next_mode = seq_pkg::MODE_ACTIVE;
    else
      next_mode = seq_pkg::MODE_DEEP;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      mode <= seq_pkg::MODE_ACTIVE;
    else
      mode <= next_mode;
  end

  // Held voltage code: captured at release, then tracked in Active mode
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      code_held <= seq_pkg::CODE_RESET;
    else if (state == seq_pkg::ST_WAIT_REL && sink_det)
      code_held <= code_in;
    else if ((state == seq_pkg::ST_RUN || state == seq_pkg::ST_GOOD) && mode == seq_pkg::MODE_ACTIVE)
      code_held <= code_in;
  end

  // Code or mode change blanks power-good faults for a window
  // Code compare only where the held code tracks, so sleep modes do not mask forever
  assign transition = (next_mode != mode) ||
                      ((state == seq_pkg::ST_RUN || state == seq_pkg::ST_GOOD) &&
                       mode == seq_pkg::MODE_ACTIVE && code_in != code_held);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      mask_count <= 6'h00;
    else if (transition)
      mask_count <= 6'(seq_pkg::MASK_SW_CYCLES);
    else if (sw_tick && mask_count != 6'h00)
      mask_count <= mask_count - 6'h01;
  end
  assign masked = (mask_count != 6'h00) || transition;

  // Fault counters in switching cycles
  fault_cycle_counter #(
    .UP_DOWN(1'b0),
    .LIMIT(seq_pkg::UV_TRIP_COUNT)
  ) u_uv_counter (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(!enabled || state == seq_pkg::ST_OFF), // Trip survives FAULT
    .i_tick(sw_tick),
    .i_cond(uv && regulating),
    .o_trip(uv_trip)
  );

  fault_cycle_counter #(
    .UP_DOWN(1'b1),
    .LIMIT(seq_pkg::FAULT_SW_CYCLES)
  ) u_oc_counter (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(!enabled || state == seq_pkg::ST_OFF), // Trip survives FAULT
    .i_tick(sw_tick),
    .i_cond(oc && regulating),
    .o_trip(oc_trip)
  );

  // Overvoltage latch, cleared only by reset or disable
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !enabled)
      ov_latch <= 1'b0;
    else if (regulating && ov && !masked)
      ov_latch <= 1'b1;
  end
  assign any_fault = uv_trip || oc_trip || ov_latch;

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      seq_pkg::ST_OFF:
        if (enabled)
          next_state = seq_pkg::ST_BOOT;
      seq_pkg::ST_BOOT:
        if (boot_ok)
          next_state = seq_pkg::ST_WAIT_REL;
      seq_pkg::ST_WAIT_REL:
        if (sink_det)
          next_state = seq_pkg::ST_HOLD;
      seq_pkg::ST_HOLD:
        if (ramp_count == 10'(seq_pkg::RAMP_DELAY_CYCLES - 1))
          next_state = seq_pkg::ST_RUN;
      seq_pkg::ST_RUN:
        if (pg_expired)
          next_state = seq_pkg::ST_GOOD;
      seq_pkg::ST_GOOD:
        next_state = seq_pkg::ST_GOOD;
      seq_pkg::ST_FAULT:
        next_state = seq_pkg::ST_FAULT;
      default:
        next_state = seq_pkg::ST_OFF;
    endcase
    if (any_fault && state != seq_pkg::ST_OFF)
      next_state = seq_pkg::ST_FAULT;
    if (!enabled)
      next_state = seq_pkg::ST_OFF;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      state <= seq_pkg::ST_OFF;
    else
      state <= next_state;
  end

  assign regulating = (state == seq_pkg::ST_BOOT) || (state == seq_pkg::ST_WAIT_REL) ||
                      (state == seq_pkg::ST_HOLD) || (state == seq_pkg::ST_RUN) ||
                      (state == seq_pkg::ST_GOOD);

  // Delay before ramp to the voltage code
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state != seq_pkg::ST_HOLD)
      ramp_count <= 10'h000;
    else
      ramp_count <= ramp_count + 10'h001;
  end

  // Power-good delay timer, started by the sink-current detection
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !(state == seq_pkg::ST_HOLD || state == seq_pkg::ST_RUN))
      pg_count <= 12'h000;
    else if (sw_tick && !pg_expired)
      pg_count <= pg_count + 12'h001;
  end
  assign pg_expired = (pg_count == 12'(seq_pkg::PG_DELAY_SW_CYCLES));

  // Regulation target and DAC code
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_target_sel <= seq_pkg::TGT_BOOT;
      o_dac_code <= seq_pkg::CODE_RESET;
    end
    else
    begin
      o_dac_code <= code_held;
      if (state == seq_pkg::ST_RUN || state == seq_pkg::ST_GOOD)
      begin
        case (mode)
          seq_pkg::MODE_DEEP: o_target_sel <= seq_pkg::TGT_DEEP;
          seq_pkg::MODE_DEEPER: o_target_sel <= seq_pkg::TGT_DEEPER;
          default: o_target_sel <= seq_pkg::TGT_CODE;
        endcase
      end
      else
        o_target_sel <= seq_pkg::TGT_BOOT;
    end
  end

  // Discontinuous switching in sleep modes only, from current feedback
  assign dcm_en = (state == seq_pkg::ST_RUN || state == seq_pkg::ST_GOOD) &&
                  (mode != seq_pkg::MODE_ACTIVE);

  // Three-state hold until the next switching cycle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || sw_tick)
      tristate <= 1'b0;
    else if (dcm_en && neg_cur && !pwm_hi)
      tristate <= 1'b1;
  end

  // Gate drive outputs, both off outside regulation
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_high_side_on <= 1'b0;
      o_low_side_on <= 1'b0;
    end
    else
    begin
      o_high_side_on <= regulating && pwm_hi;
      o_low_side_on <= regulating && !pwm_hi && !tristate &&
                       !(dcm_en && neg_cur);
    end
  end

  // Power-good decision: window faults drop it unless blanked
  assign pg_good = (state == seq_pkg::ST_GOOD) && !any_fault &&
                   !((ov || uv) && !masked);

  // Open-drain pin: sink unless good; the shared line reads low if any pulls
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_power_good_pin <= 1'b0;
      o_power_good_pin_oe_n <= 1'b0;
      o_system_power_ok <= 1'b0;
    end
    else
    begin
      o_power_good_pin <= 1'b0;
      o_power_good_pin_oe_n <= pg_good;
      o_system_power_ok <= pg_pin;
    end
  end

  // Status flags to pins
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_discontinuous <= 1'b0;
      o_overcurrent <= 1'b0;
    end
    else
    begin
      o_discontinuous <= dcm_en;
      o_overcurrent <= oc;
    end
  end

  // APB: zero-wait slave
  assign apb_access = i_psel && i_penable;
  assign o_pready = 1'b1;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      soft_enable <= seq_pkg::CTRL_ENABLE_RESET;
    else if (apb_access && i_pwrite && i_paddr == seq_pkg::CTRL_OFFSET)
      soft_enable <= i_pwdata[seq_pkg::CTRL_ENABLE_BIT];
  end

  // Status word assembly
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[seq_pkg::STATUS_STATE_LSB +: 7] = state;
    status_word[seq_pkg::STATUS_MODE_LSB +: 3] = mode;
    status_word[seq_pkg::STATUS_DCM_BIT] = dcm_en;
    status_word[seq_pkg::STATUS_PG_BIT] = pg_good;
    status_word[seq_pkg::STATUS_UV_BIT] = uv_trip;
    status_word[seq_pkg::STATUS_OC_BIT] = oc_trip;
    status_word[seq_pkg::STATUS_OV_BIT] = ov_latch;
    status_word[seq_pkg::STATUS_MASK_BIT] = masked;
  end

  // Read data and error for unmapped addresses
  always_comb
  begin
    o_prdata = 32'h0000_0000;
    o_pslverr = 1'b0;
    if (!apb_access)
      o_pslverr = 1'b0;
    else if (i_paddr == seq_pkg::CTRL_OFFSET)
      o_prdata = {31'h0000_0000, soft_enable};
    else if (i_paddr == seq_pkg::STATUS_OFFSET)
    begin
      o_prdata = i_pwrite ? 32'h0000_0000 : status_word;
      o_pslverr = i_pwrite;
    end
    else
      o_pslverr = 1'b1;
  end
endmodule : sleep_mode_powergood_sequencer

// File: design/seq_pkg.sv
// Constants, types and the register map of the power-good sequencer
// Notes on behaviour
// - Sleep high, deeper low: Active, voltage code
// - Both low: Deep Sleep, deep setpoint
// - Deeper high, sleep low: Deeper Sleep setpoint
// - Discontinuous switching only in sleep modes
// - Negative current ends low side until next cycle, in sleep modes only
// - Start-up regulates to boot setpoint
// - Power-good pin input during start-up, await release
// - Sink current detected starts power-good timer
// - On release capture voltage code, regulate to it
// - Wait 10 us before ramping to code
// - Power-good timer counts 3072 switching cycles
// - Power-good high only after timer expiry
// - Blank power-good faults during code/mode transitions
// - Overvoltage or undervoltage pulls power-good low
// - Overcurrent when current at or above threshold
// - Power-good lines wired together, low dominates
// - Active mode follows voltage code changes
// - Undervoltage over 32 cycles latches off
// - Overcurrent up/down count to 32 latches off
package seq_pkg;
  // Clock and switching timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int SW_FREQ_KHZ = 300;
  localparam int SW_PERIOD_CYCLES = CLK_FREQ_MHZ * 1000 / SW_FREQ_KHZ;
  localparam int RAMP_DELAY_US = 10;
  localparam int RAMP_DELAY_CYCLES = RAMP_DELAY_US * CLK_FREQ_MHZ;
  localparam int PG_DELAY_SW_CYCLES = 3072;
  localparam int FAULT_SW_CYCLES = 32;
  localparam int UV_TRIP_COUNT = FAULT_SW_CYCLES + 1;
  localparam int MASK_SW_CYCLES = 32;
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_MODE_LSB = 8;
  localparam int STATUS_DCM_BIT = 12;
  localparam int STATUS_PG_BIT = 13;
  localparam int STATUS_UV_BIT = 16;
  localparam int STATUS_OC_BIT = 17;
  localparam int STATUS_OV_BIT = 18;
  localparam int STATUS_MASK_BIT = 19;
  localparam logic [5:0] CODE_RESET = 6'h3f;
  // Sequencer states
  typedef enum logic [6:0] {
    ST_OFF      = 7'b000_0001,
    ST_BOOT     = 7'b000_0010,
    ST_WAIT_REL = 7'b000_0100,
    ST_HOLD     = 7'b000_1000,
    ST_RUN      = 7'b001_0000,
    ST_GOOD     = 7'b010_0000,
    ST_FAULT    = 7'b100_0000
  } seq_state_t;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b001,
    MODE_DEEP   = 3'b010,
    MODE_DEEPER = 3'b100
  } mode_t;
  // Regulation target select
  typedef enum logic [3:0] {
    TGT_BOOT   = 4'b0001,
    TGT_CODE   = 4'b0010,
    TGT_DEEP   = 4'b0100,
    TGT_DEEPER = 4'b1000
  } target_t;
endpackage : seq_pkg

// File: design/fault_cycle_counter.sv
// Switching-cycle fault counter with latched trip
`timescale 1ns/1ps
module fault_cycle_counter #(
  parameter bit UP_DOWN = 1'b0,
  parameter int LIMIT = 32
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic i_cond,
  output logic o_trip
);
  logic [6:0] count;

  // Count cycles while the condition holds; otherwise drain or restart
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clear)
      count <= 7'h00;
    else if (i_tick && i_cond && count != LIMIT[6:0])
      count <= count + 7'h01;
    else if (i_tick && !i_cond)
    begin
      if (!UP_DOWN)
        count <= 7'h00;
      else if (count != 7'h00)
        count <= count - 7'h01;
    end
  end

  // Trip latches until cleared
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clear)
      o_trip <= 1'b0;
    else if (count == LIMIT[6:0])
      o_trip <= 1'b1;
  end
endmodule : fault_cycle_counter

// File: tb/seq_chk.sv
// Port-level assertions for the power-good sequencer
`timescale 1ns/1ps
module seq_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic i_enable,
  input wire logic i_sleep_request_in,
  input wire logic i_deeper_sleep_request_in,
  input wire logic i_uv_cmp,
  input wire logic i_oc_cmp,
  input wire logic o_pslverr,
  input wire logic o_power_good_pin,
  input wire logic o_power_good_pin_oe_n,
  input wire logic [3:0] o_target_sel,
  input wire logic o_high_side_on,
  input wire logic o_low_side_on,
  input wire logic o_discontinuous,
  input wire logic o_overcurrent
);
  localparam int SW = seq_pkg::SW_PERIOD_CYCLES;
  // Free-running switching tick: the first counted period may be partial
  localparam int PG_MIN = (seq_pkg::PG_DELAY_SW_CYCLES - 1) * SW;
  localparam int UV_MAX = (seq_pkg::UV_TRIP_COUNT + seq_pkg::MASK_SW_CYCLES + 2) * SW;
  localparam int OC_MAX = (seq_pkg::FAULT_SW_CYCLES + 2) * SW;
  logic [20:0] en_cnt;
  logic [15:0] uv_cnt;
  logic [15:0] oc_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Saturating run lengths of enable, undervoltage and overcurrent
  always_ff @(posedge i_clk)
  begin
    en_cnt <= (i_sys_rst || !i_enable) ? '0 : en_cnt + 21'(en_cnt < 21'(PG_MIN));
    uv_cnt <= (i_sys_rst || !i_uv_cmp) ? '0 : uv_cnt + 16'(uv_cnt < 16'(UV_MAX));
    oc_cnt <= (i_sys_rst || !i_oc_cmp) ? '0 : oc_cnt + 16'(oc_cnt < 16'(OC_MAX));
  end
  sequence s_active;
    i_sleep_request_in && !i_deeper_sleep_request_in;
  endsequence
  sequence s_oc_steady;
    $stable(i_oc_cmp) [*5];
  endsequence
  a_gates_exclusive: assert property (!(o_high_side_on && o_low_side_on))
    else $error("both gate drives on");
  a_target_onehot: assert property ($onehot(o_target_sel))
    else $error("target select not one-hot");
  a_pin_sinks_only: assert property (o_power_good_pin == 1'b0)
    else $error("power-good pin driven high");
  a_active_no_dcm: assert property (s_active [*6] |-> !o_discontinuous)
    else $error("discontinuous in active mode");
  a_oc_flag: assert property (s_oc_steady |-> o_overcurrent == i_oc_cmp)
    else $error("overcurrent flag wrong");
  a_release_late: assert property ($rose(o_power_good_pin_oe_n) |-> en_cnt >= 21'(PG_MIN))
    else $error("power-good released too early");
  a_release_code: assert property ($rose(o_power_good_pin_oe_n) |-> o_target_sel != 4'b0001)
    else $error("power-good released on boot target");
  a_uv_latch: assert property (uv_cnt >= 16'(UV_MAX) |-> !o_power_good_pin_oe_n)
    else $error("long undervoltage left line released");
  a_oc_latch: assert property (oc_cnt >= 16'(OC_MAX) |-> !o_power_good_pin_oe_n)
    else $error("long overcurrent left line released");
  a_apb_err: assert property (i_psel && i_penable |-> o_pslverr == ((i_paddr != 8'h00 && i_paddr != 8'h04)
    || (i_pwrite && i_paddr == 8'h04)))
    else $error("slave error mismatch");
endmodule : seq_chk

bind sleep_mode_powergood_sequencer seq_chk chk_i (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_enable, .i_sleep_request_in, .i_deeper_sleep_request_in, .i_uv_cmp, .i_oc_cmp, .o_pslverr,
  .o_power_good_pin, .o_power_good_pin_oe_n, .o_target_sel, .o_high_side_on, .o_low_side_on,
  .o_discontinuous, .o_overcurrent);

// File: tb/chipset_model.sv
// Chipset sleep logic and companion rail regulators
`timescale 1ns/1ps
module chipset_model (
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  input wire logic i_comp_ok,
  input wire logic i_oe_n,
  output logic o_sleep = 1'b1,
  output logic o_deeper = 1'b0,
  output logic o_line,
  output logic o_sink
);
  // Stop and deeper-sleep requests onto the two sleep inputs
  always_ff @(posedge i_clk)
  begin
    o_sleep <= i_mode[0];
    o_deeper <= i_mode[1];
  end
  // Pulled-up shared line, any party low wins
  assign o_line = i_comp_ok & i_oe_n;
  // Sink current only once companions release and device pulls
  assign o_sink = i_comp_ok & ~i_oe_n;
endmodule : chipset_model

// File: tb/tb.sv
// Self-checking bench for the power-good sequencer
`timescale 1ns/1ps
module tb;
  localparam int SW = seq_pkg::SW_PERIOD_CYCLES;
  logic i_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, en = 1'b0, boot = 1'b0, hold = 1'b0;
  logic ov = 1'b0, uv = 1'b0, oc = 1'b0, neg = 1'b0, pwm = 1'b0, comp_ok = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [5:0] code = 6'h00;
  logic [1:0] mode = 2'b01;
  logic [31:0] prdata, rdata;
  logic [3:0] tgt;
  logic [5:0] dac;
  logic pready, pslverr, serr, sleep, deeper, line, sink, oe_n, pok, ls, dcm, ovc;
  int fail_count = 0;
  int checked = 0;
  time t0;
  sleep_mode_powergood_sequencer uut (.i_clk(i_clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_enable(en), .i_sleep_request_in(sleep), .i_deeper_sleep_request_in(deeper),
    .i_voltage_code(code), .i_boot_reached(boot), .i_pg_sink_detect(sink), .i_ov_cmp(ov), .i_uv_cmp(uv),
    .i_oc_cmp(oc), .i_neg_current(neg), .i_pwm_high(pwm), .i_power_good_pin(line), .o_power_good_pin(),
    .o_power_good_pin_oe_n(oe_n), .o_system_power_ok(pok), .o_target_sel(tgt), .o_dac_code(dac),
    .o_high_side_on(), .o_low_side_on(ls), .o_discontinuous(dcm), .o_overcurrent(ovc));
  chipset_model part (.i_clk(i_clk), .i_mode(mode), .i_comp_ok(comp_ok), .i_oe_n(oe_n),
    .o_sleep(sleep), .o_deeper(deeper), .o_line(line), .o_sink(sink));
  // Clock, 10 ns period
  initial
    forever #5 i_clk = ~i_clk;
  // Modulator stand-in, random duty unless held low
  always @(posedge i_clk)
    pwm <= hold ? 1'b0 : 1'($urandom);
  // Watchdog sized well past the expected run
  initial
  begin
    #900_000;
    fail_count++;
    give_verdict();
  end
  function automatic logic [2:0] mode_of(input logic [1:0] m);
    return m[1] ? 3'h4 : (m[0] ? 3'h1 : 3'h2);
  endfunction : mode_of
  task automatic give_verdict;
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    // Only the watchdog ends a stalled access
    do
    begin
      @(posedge i_clk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask : apb
  // Poll the state field until it reads s
  task automatic wst(input logic [6:0] s);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 8'h04, 32'h0000_0000);
      n++;
    end
    while (rdata[6:0] !== s && n < 9000);
    chk(rdata[6:0], s);
  endtask : wst
  // Start-up up to RUN, before power-good, with a code change while holding
  task automatic start;
    int d;
    comp_ok <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0001);
    en <= 1'b1;
    boot <= 1'b1;
    wst(7'h04);
    chk(tgt, 4'b0001);
    comp_ok <= 1'b1;
    wst(7'h08);
    t0 = $time;
    chk(dac, code);
    code <= 6'($urandom);
    wst(7'h10);
    d = int'(($time - t0) / 10);
    chk(d >= 990 && d <= 1010, 1'b1);
    wt(8);
    chk(dac, code);
    chk(tgt, 4'b0010);
    chk(oe_n, 1'b0);
  endtask : start
  // Latched fault holds until soft disable
  task automatic recover;
    wt(400);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rdata[6:0], 7'h40);
    chk(oe_n, 1'b0);
    chk(pok, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0000);
    wst(7'h01);
  endtask : recover
  // Main sequence
  initial
  begin
    void'($urandom(67425));
    code = 6'($urandom);
    wt(16);
    rst <= 1'b0;
    chk(tgt, 4'b0001);
    chk(dac, 6'h3f);
    chk(oe_n, 1'b0);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rdata, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0000);
    chk(serr, 1'b1);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(serr, 1'b1);
    wst(7'h01);
    start();
    hold <= 1'b1;
    neg <= 1'b1;
    for (int m = 1; m < 5; m++)
    begin
      mode <= 2'(m);
      wt(12);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(rdata[10:8], mode_of(2'(m)));
      chk(tgt, {mode_of(2'(m)), 1'b0});
      chk(dcm, 2'(m) != 2'b01);
      chk(ls, 2'(m) == 2'b01);
    end
    mode <= 2'b01;
    hold <= 1'b0;
    neg <= 1'b0;
    oc <= 1'b1;
    wt(20 * SW);
    oc <= 1'b0;
    wt(30 * SW);
    oc <= 1'b1;
    wt(20 * SW);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rdata[6:0], 7'h10);
    chk(ovc, 1'b1);
    wst(7'h40);
    chk(rdata[17], 1'b1);
    oc <= 1'b0;
    recover();
    start();
    uv <= 1'b1;
    wt(32 * SW - 10);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rdata[6:0], 7'h10);
    wst(7'h40);
    chk(rdata[16], 1'b1);
    uv <= 1'b0;
    recover();
    start();
    code <= code + 6'h01;
    wt(5 * SW);
    ov <= 1'b1;
    wt(20);
    ov <= 1'b0;
    wt(10);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rdata[6:0], 7'h10);
    wt(40 * SW);
    ov <= 1'b1;
    wst(7'h40);
    chk(rdata[18], 1'b1);
    ov <= 1'b0;
    recover();
    give_verdict();
  end
endmodule : tb
